// [shunt_current_spectral_features.sv]
// Shunt current capture, overlapped framing, spectrum in dBFS, peak feature
// extraction, two-class scoring and serial report of results and waveforms.
// Assumes the converter answers each start pulse with one valid pulse.
`timescale 1ns/1ps
`default_nettype none
module shunt_current_spectral_features
  import feature_pkg::*;
#(
  parameter int TICK_CYCLES_P = TICK_CYCLES,
  parameter logic signed [7:0]  CLASS_WEIGHT [FEAT_LEN] = '{default: 8'sh01},
  parameter logic signed [25:0] CLASS_BIAS = 26'sh0000000
) (
  // Clock and reset
  input  wire logic        clk_in,
  input  wire logic        srst_in,
  // Converter
  output logic             adc_start_out,
  input  wire logic        adc_valid_in,
  input  wire logic [11:0] adc_u_in,
  input  wire logic [11:0] adc_v_in,
  input  wire logic [11:0] adc_w_in,
  // Host serial link
  output logic             uart_tx_out,
  // Result
  output logic [7:0]       anomaly_out,
  output logic [7:0]       normal_out,
  output logic [7:0]       peak_bin_out,
  output logic             result_valid_out
);
  function automatic logic [9:0] log2_q4(input logic [63:0] v);
    logic [5:0]  pos;
    logic [63:0] sh;
    pos = '0;
    for (int i = 0; i < 64; i++) begin
      if (v[i]) pos = 6'(i);
    end
    sh = v << (6'd63 - pos);
    return {pos, sh[62:59]};
  endfunction : log2_q4

  // Sampler
  logic [13:0] tick_reg, tick_next;
  logic        start_reg, start_next;
  logic [9:0]  wptr_reg, wptr_next, fill_reg, fill_next, need;
  logic        first_reg, first_next, frame_go;
  logic [11:0] ph_u_reg, ph_v_reg, ph_w_reg, ph_u_next, ph_v_next, ph_w_next;
  logic [11:0] ring [RING_LEN];
  engine_state_t state_reg, state_next;

  always_comb begin
    start_next = (tick_reg == 14'(TICK_CYCLES_P - 1));
    tick_next  = start_next ? '0 : 14'(tick_reg + 1'b1);
    need       = first_reg ? 10'(FRAME_LEN) : 10'(FRAME_LEN - OVERLAP);
    frame_go   = (state_reg == ST_IDLE) && (fill_reg >= need);
    first_next = frame_go ? 1'b0 : first_reg;
    fill_next  = 10'(fill_reg - (frame_go ? need : 10'h000) + (adc_valid_in ? 10'h001 : 10'h000));
    wptr_next  = adc_valid_in ? 10'(wptr_reg + 1'b1) : wptr_reg;
    ph_u_next  = adc_valid_in ? adc_u_in : ph_u_reg;
    ph_v_next  = adc_valid_in ? adc_v_in : ph_v_reg;
    ph_w_next  = adc_valid_in ? adc_w_in : ph_w_reg;
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      tick_reg  <= '0;
      start_reg <= 1'b0;
      wptr_reg  <= '0;
      fill_reg  <= '0;
      first_reg <= 1'b1;
      ph_u_reg  <= '0;
      ph_v_reg  <= '0;
      ph_w_reg  <= '0;
    end else begin
      tick_reg  <= tick_next;
      start_reg <= start_next;
      wptr_reg  <= wptr_next;
      fill_reg  <= fill_next;
      first_reg <= first_next;
      ph_u_reg  <= ph_u_next;
      ph_v_reg  <= ph_v_next;
      ph_w_reg  <= ph_w_next;
    end
  end

  // Only U phase enters the frame ring
  always_ff @(posedge clk_in) begin
    if (adc_valid_in) begin
      ring[wptr_reg] <= adc_u_in;
    end
  end
  assign adc_start_out = start_reg;

  tick_gap_a: assert property (@(posedge clk_in) disable iff (srst_in)
    adc_start_out |=> !adc_start_out [*8]) else $error("Sampling ticks too close");
  frame_need_a: assert property (@(posedge clk_in) disable iff (srst_in)
    frame_go && !first_reg |-> fill_reg >= 10'(FRAME_LEN - OVERLAP)) else $error("Overlap frame started early");
  first_frame_a: assert property (@(posedge clk_in) disable iff (srst_in)
    frame_go && first_reg |-> fill_reg >= 10'(FRAME_LEN)) else $error("First frame started short");
  u_only_a: assert property (@(posedge clk_in) disable iff (srst_in)
    adc_valid_in |=> ring[$past(wptr_reg)] == $past(adc_u_in)) else $error("Ring not fed from U phase");

  // Transform engine
  logic [9:0]  base_reg, base_next;
  logic [8:0]  n_reg, n_next;
  logic [7:0]  bin_reg, bin_next, peak_reg, peak_next, fidx;
  logic signed [31:0] s1_reg, s1_next, s2_reg, s2_next;
  logic signed [15:0] oc_reg, oc_next, os_reg, os_next;
  logic signed [11:0] pkdb_reg, pkdb_next, db_val;
  logic [4:0]  fi_reg, fi_next;
  logic signed [25:0] score_reg, score_next, scaled;
  logic [7:0]  anom_reg, anom_next, norm_reg, norm_next, pkout_reg, pkout_next;
  logic        rv_reg, rv_next, db_we;
  logic signed [11:0] db_mem [HALF_BINS];
  logic signed [16:0] coef;
  logic signed [49:0] cs1;
  logic signed [33:0] s0;
  logic signed [12:0] xc;
  logic signed [71:0] pw;
  logic signed [23:0] dbw;
  logic signed [9:0]  fsum;

  always_comb begin
    state_next = state_reg;
    base_next  = base_reg;
    n_next     = n_reg;
    bin_next   = bin_reg;
    s1_next    = s1_reg;
    s2_next    = s2_reg;
    oc_next    = oc_reg;
    os_next    = os_reg;
    peak_next  = peak_reg;
    pkdb_next  = pkdb_reg;
    fi_next    = fi_reg;
    score_next = score_reg;
    anom_next  = anom_reg;
    norm_next  = norm_reg;
    pkout_next = pkout_reg;
    rv_next    = 1'b0;
    db_we      = 1'b0;
    coef = 17'(oc_reg) <<< 1;
    cs1  = 50'(coef) * 50'(s1_reg);
    xc   = $signed({1'b0, ring[10'(base_reg + 10'(n_reg))]}) - $signed({1'b0, ADC_MID});
    s0   = 34'(xc) + 34'(cs1 >>> 14) - 34'(s2_reg);
    pw   = 72'(s1_reg) * 72'(s1_reg) + 72'(s2_reg) * 72'(s2_reg) - ((72'(cs1) >>> 14) * 72'(s2_reg));
    // Power to dB relative to full scale
    dbw    = (24'($signed({2'b00, log2_q4(pw[71] ? 64'h0 : pw[63:0])})) - 24'(LOG2Q_FULL_SCALE))
             * 24'(DB_SCALE);
    db_val = 12'(dbw >>> 8);
    fsum = $signed({2'b00, peak_reg}) + $signed({5'h00, fi_reg}) - 10'sd10;
    fidx = (fsum < 10'sd1) ? 8'h01 : ((fsum > 10'sd255) ? 8'hFF : 8'(fsum));
    scaled = score_reg >>> SCORE_SHIFT;
    unique case (state_reg)
      ST_IDLE: begin
        if (frame_go) begin
          base_next  = 10'(wptr_reg - 10'(FRAME_LEN));
          bin_next   = 8'h01;
          oc_next    = ROT_COS;
          os_next    = ROT_SIN;
          state_next = ST_BIN;
        end
      end
      ST_BIN: begin
        s1_next    = '0;
        s2_next    = '0;
        n_next     = '0;
        state_next = ST_ITER;
      end
      ST_ITER: begin
        s1_next = 32'(s0);
        s2_next = s1_reg;
        n_next  = 9'(n_reg + 1'b1);
        if (n_reg == 9'(FRAME_LEN - 1)) state_next = ST_POWER;
      end
      ST_POWER: begin
        db_we = 1'b1;
        if (bin_reg == 8'h01 || db_val > pkdb_reg) begin
          peak_next = bin_reg;
          pkdb_next = db_val;
        end
        oc_next = 16'((32'(oc_reg) * 32'(ROT_COS) - 32'(os_reg) * 32'(ROT_SIN)) >>> 14);
        os_next = 16'((32'(os_reg) * 32'(ROT_COS) + 32'(oc_reg) * 32'(ROT_SIN)) >>> 14);
        // Stop at the top of the lower half
        if (bin_reg == 8'(HALF_BINS - 1)) begin
          fi_next    = '0;
          score_next = CLASS_BIAS;
          state_next = ST_FEAT;
        end else begin
          bin_next   = 8'(bin_reg + 1'b1);
          state_next = ST_BIN;
        end
      end
      ST_FEAT: begin
        // Weighted sum over the 21 feature bins
        score_next = 26'(score_reg + 26'(CLASS_WEIGHT[fi_reg]) * 26'(db_mem[fidx]));
        fi_next    = 5'(fi_reg + 1'b1);
        if (fi_reg == 5'(FEAT_LEN - 1)) state_next = ST_CLASS;
      end
      ST_CLASS: begin
        // Anomaly probability, normal is its complement
        if (scaled < -26'sd128) anom_next = 8'h00;
        else if (scaled > 26'sd127) anom_next = 8'hFF;
        else anom_next = 8'(scaled + 26'sd128);
        norm_next  = 8'hFF - anom_next;
        pkout_next = peak_reg;
        rv_next    = 1'b1;
        state_next = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      state_reg <= ST_IDLE;
      base_reg  <= '0;
      n_reg     <= '0;
      bin_reg   <= 8'h01;
      s1_reg    <= '0;
      s2_reg    <= '0;
      oc_reg    <= ROT_COS;
      os_reg    <= ROT_SIN;
      peak_reg  <= 8'h01;
      pkdb_reg  <= '0;
      fi_reg    <= '0;
      score_reg <= '0;
      anom_reg  <= '0;
      norm_reg  <= 8'hFF;
      pkout_reg <= '0;
      rv_reg    <= 1'b0;
    end else begin
      state_reg <= state_next;
      base_reg  <= base_next;
      n_reg     <= n_next;
      bin_reg   <= bin_next;
      s1_reg    <= s1_next;
      s2_reg    <= s2_next;
      oc_reg    <= oc_next;
      os_reg    <= os_next;
      peak_reg  <= peak_next;
      pkdb_reg  <= pkdb_next;
      fi_reg    <= fi_next;
      score_reg <= score_next;
      anom_reg  <= anom_next;
      norm_reg  <= norm_next;
      pkout_reg <= pkout_next;
      rv_reg    <= rv_next;
    end
  end

  always_ff @(posedge clk_in) begin
    if (db_we) begin
      db_mem[bin_reg] <= db_val;
    end
  end
  assign anomaly_out      = anom_reg;
  assign normal_out       = norm_reg;
  assign peak_bin_out     = pkout_reg;
  assign result_valid_out = rv_reg;

  peak_no_dc_a: assert property (@(posedge clk_in) disable iff (srst_in)
    result_valid_out |-> peak_bin_out != 8'h00) else $error("Peak landed on DC bin");
  feat_clamp_a: assert property (@(posedge clk_in) disable iff (srst_in)
    state_reg == ST_FEAT |-> fidx >= 8'h01 && (peak_reg < 8'h0B || fidx >= 8'(peak_reg - 8'h0A)))
    else $error("Feature index out of range");
  feat_count_a: assert property (@(posedge clk_in) disable iff (srst_in)
    $rose(state_reg == ST_FEAT) |-> (state_reg == ST_FEAT) [*8] ##14 state_reg == ST_CLASS)
    else $error("Feature walk not 21 bins");
  prob_sum_a: assert property (@(posedge clk_in) disable iff (srst_in)
    result_valid_out |-> 9'(anomaly_out) + 9'(normal_out) == 9'h0FF) else $error("Probabilities do not sum");
  db_ref_a: assert property (@(posedge clk_in) disable iff (srst_in)
    db_we && pw == 72'h00_0000_0100_0000_0000 |-> db_val == 12'sh000) else $error("Full scale not 0 dB");

  // Message builder
  fifo_if #(.WIDTH(FIFO_W)) txf ();
  logic        wpend_reg, wpend_next, rpend_reg, rpend_next;
  logic        mbusy_reg, mbusy_next, mres_reg, mres_next;
  logic [2:0]  midx_reg, midx_next;
  logic [35:0] snap_reg, snap_next;
  logic [47:0] msg;

  always_comb begin
    msg = mres_reg ? {8'h00, 8'h00, pkout_reg, norm_reg, anom_reg, HDR_RESULT}
                   : {4'h0, snap_reg[11:0], 4'h0, snap_reg[23:12], 4'h0, snap_reg[35:24]};
    txf.wr_valid = mbusy_reg;
    txf.wr_data  = (midx_reg == 3'h0 && !mres_reg) ? HDR_WAVE : msg[8'(midx_reg - (mres_reg ? 3'h0 : 3'h1)) * 8 +: 8];
    mbusy_next = mbusy_reg;
    mres_next  = mres_reg;
    midx_next  = midx_reg;
    snap_next  = snap_reg;
    if (mbusy_reg && txf.wr_ready) begin
      midx_next = 3'(midx_reg + 1'b1);
      if (midx_reg == (mres_reg ? RESULT_LAST : WAVE_LAST)) mbusy_next = 1'b0;
    end
    // Set wins over the clear when both land together
    rpend_next = rv_reg || (rpend_reg && !(!mbusy_reg));
    wpend_next = adc_valid_in || (wpend_reg && !(!mbusy_reg && !rpend_reg));
    if (!mbusy_reg && (rpend_reg || wpend_reg)) begin
      mbusy_next = 1'b1;
      mres_next  = rpend_reg;
      midx_next  = '0;
      snap_next  = {ph_u_reg, ph_v_reg, ph_w_reg};
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      wpend_reg <= 1'b0;
      rpend_reg <= 1'b0;
      mbusy_reg <= 1'b0;
      mres_reg  <= 1'b0;
      midx_reg  <= '0;
      snap_reg  <= '0;
    end else begin
      wpend_reg <= wpend_next;
      rpend_reg <= rpend_next;
      mbusy_reg <= mbusy_next;
      mres_reg  <= mres_next;
      midx_reg  <= midx_next;
      snap_reg  <= snap_next;
    end
  end

  byte_fifo #(.WIDTH(FIFO_W), .DEPTH(FIFO_DEPTH)) tx_fifo (
    .clk_in  (clk_in),
    .srst_in (srst_in),
    .f       (txf)
  );

  // Serial transmitter, 8N1
  logic [6:0] baud_reg, baud_next;
  logic [9:0] sh_reg, sh_next;
  logic [3:0] bits_reg, bits_next;
  logic       busy_reg, busy_next, tx_reg, tx_next, bit_en;

  always_comb begin
    // Bit period from the baud divider
    bit_en    = busy_reg && (baud_reg == 7'(BAUD_CYCLES - 1));
    baud_next = (!busy_reg || bit_en) ? '0 : 7'(baud_reg + 1'b1);
    sh_next   = sh_reg;
    bits_next = bits_reg;
    busy_next = busy_reg;
    txf.rd_ready = !busy_reg;
    if (!busy_reg && txf.rd_valid) begin
      sh_next   = {1'b1, txf.rd_data, 1'b0};
      bits_next = 4'h9;
      busy_next = 1'b1;
    end else if (bit_en) begin
      sh_next   = {1'b1, sh_reg[9:1]};
      bits_next = 4'(bits_reg - 1'b1);
      if (bits_reg == 4'h0) busy_next = 1'b0;
    end
    tx_next = busy_next ? sh_next[0] : 1'b1;
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      baud_reg <= '0;
      sh_reg   <= 10'h3FF;
      bits_reg <= '0;
      busy_reg <= 1'b0;
      tx_reg   <= 1'b1;
    end else begin
      baud_reg <= baud_next;
      sh_reg   <= sh_next;
      bits_reg <= bits_next;
      busy_reg <= busy_next;
      tx_reg   <= tx_next;
    end
  end
  assign uart_tx_out = tx_reg;

  baud_period_a: assert property (@(posedge clk_in) disable iff (srst_in)
    bit_en && bits_reg != 4'h0 |=> !bit_en [*8] ##70 bit_en) else $error("Baud period wrong");
endmodule : shunt_current_spectral_features
`default_nettype wire

// [feature_pkg.sv]
// Shared constants and types for the shunt current spectral feature block.
// Assumes a 20 MHz system clock and a 12-bit converter outside the block.
`default_nettype none
package feature_pkg;
  // Clock and timing
  localparam int CLK_HZ          = 20_000_000;
  localparam int SAMPLE_RATE_KHZ = 2;
  localparam int TICK_CYCLES     = CLK_HZ / (SAMPLE_RATE_KHZ * 1000);
  localparam int BAUD_RATE       = 256000;
  localparam int BAUD_CYCLES     = CLK_HZ / BAUD_RATE;
  // Sample and frame geometry
  localparam int SAMPLE_W        = 12;
  localparam int FRAME_LEN       = 512;
  localparam int OVERLAP         = 64;
  localparam int RING_LEN        = 1024;
  localparam int HALF_BINS       = 256;
  localparam int FEAT_SIDE       = 10;
  localparam int FEAT_LEN        = 2 * FEAT_SIDE + 1;
  localparam logic [11:0] ADC_MID = 12'h800;
  // Full scale of 4095 LSB is the 0 dB level
  localparam int FULL_SCALE      = 4095;
  // log2 of (FULL_SCALE * FRAME_LEN / 2)^2 in Q4
  localparam logic signed [11:0] LOG2Q_FULL_SCALE = 12'sh280;
  // 10*log10(2) in Q8
  localparam logic signed [11:0] DB_SCALE = 12'sh303;
  // Bin-step rotation cos/sin of 2*pi/512 in Q14
  localparam logic signed [15:0] ROT_COS = 16'sh3FFF;
  localparam logic signed [15:0] ROT_SIN = 16'sh00C9;
  localparam int SCORE_SHIFT     = 4;
  // Serial framing
  localparam int FIFO_W          = 8;
  localparam int FIFO_DEPTH      = 16;
  localparam logic [7:0] HDR_WAVE   = 8'h55;
  localparam logic [7:0] HDR_RESULT = 8'hAA;
  localparam logic [2:0] WAVE_LAST   = 3'h6;
  localparam logic [2:0] RESULT_LAST = 3'h3;
  typedef enum logic [2:0] {ST_IDLE, ST_BIN, ST_ITER, ST_POWER, ST_FEAT, ST_CLASS} engine_state_t;
endpackage : feature_pkg
`default_nettype wire

// [fifo_if.sv]
// Valid/ready carrier between a byte source and the transmit FIFO.
// Assumes both ends share one clock.
`timescale 1ns/1ps
`default_nettype none
interface fifo_if #(parameter int WIDTH = 8);
  logic             wr_valid;
  logic             wr_ready;
  logic [WIDTH-1:0] wr_data;
  logic             rd_valid;
  logic             rd_ready;
  logic [WIDTH-1:0] rd_data;
  modport source (output wr_valid, output wr_data, input wr_ready);
  modport buffer (input wr_valid, input wr_data, output wr_ready,
                  output rd_valid, output rd_data, input rd_ready);
  modport sink   (input rd_valid, input rd_data, output rd_ready);
endinterface : fifo_if
`default_nettype wire

// [byte_fifo.sv]
// Flip-flop FIFO with valid/ready on both sides.
// Assumes a single clock and synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input  wire logic clk_in,
  input  wire logic srst_in,
  // Data carrier
  fifo_if.buffer    f
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wp_reg, wp_next, rp_reg, rp_next;
  logic [AW:0]      cnt_reg, cnt_next;
  logic             push, pop;

  assign f.wr_ready = (cnt_reg != (AW+1)'(DEPTH));
  assign f.rd_valid = (cnt_reg != '0);
  assign f.rd_data  = mem[rp_reg];

  always_comb begin
    push     = f.wr_valid && f.wr_ready;
    pop      = f.rd_valid && f.rd_ready;
    wp_next  = push ? AW'(wp_reg + 1'b1) : wp_reg;
    rp_next  = pop ? AW'(rp_reg + 1'b1) : rp_reg;
    cnt_next = (AW+1)'(cnt_reg + (push ? 1'b1 : 1'b0) - (pop ? 1'b1 : 1'b0));
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      wp_reg  <= '0;
      rp_reg  <= '0;
      cnt_reg <= '0;
    end else begin
      wp_reg  <= wp_next;
      rp_reg  <= rp_next;
      cnt_reg <= cnt_next;
    end
  end

  always_ff @(posedge clk_in) begin
    if (push) begin
      mem[wp_reg] <= f.wr_data;
    end
  end

  fifo_bound_a: assert property (@(posedge clk_in) disable iff (srst_in)
    cnt_reg <= (AW+1)'(DEPTH)) else $error("FIFO count above depth");
endmodule : byte_fifo
`default_nettype wire

// [adc_model.sv]
// Behavioural three-phase converter answering each start pulse within the sample budget with one valid pulse.
// Assumes the bench grants a sample budget and picks the answer delay and U tone.
`timescale 1ns/1ps
`default_nettype none
module adc_model (
  // Clock and reset
  input  wire logic        clk_in,
  input  wire logic        srst_in,
  // Bench control
  input  wire logic [15:0] budget_in,
  input  wire logic [3:0]  delay_in,
  input  wire logic [7:0]  half_in,
  // Converter side
  input  wire logic        adc_start_in,
  output logic             adc_valid_out,
  output logic [11:0]      u_out,
  output logic [11:0]      v_out,
  output logic [11:0]      w_out,
  output logic [15:0]      issued_out
);
  logic       pending;
  logic [3:0] wait_cnt;

  initial begin
    adc_valid_out = 1'b0;
    u_out = 12'h000;
    v_out = 12'h000;
    w_out = 12'h000;
    issued_out = 16'h0000;
    pending = 1'b0;
    wait_cnt = 4'h0;
  end

  always @(posedge clk_in) begin
    adc_valid_out <= 1'b0;
    // Released lines show inverted data
    if (adc_valid_out) begin
      u_out <= ~u_out;
      v_out <= ~v_out;
      w_out <= ~w_out;
    end
    if (srst_in) begin
      pending <= 1'b0;
    end else if (adc_start_in && issued_out < budget_in) begin
      pending <= 1'b1;
      wait_cnt <= delay_in;
    end else if (pending && wait_cnt != 4'h0) begin
      wait_cnt <= wait_cnt - 4'h1;
    end else if (pending) begin
      pending <= 1'b0;
      adc_valid_out <= 1'b1;
      u_out <= (((issued_out / {8'h00, half_in}) % 16'h0002) != 16'h0000) ? 12'h700 : 12'h100;
      v_out <= issued_out[2] ? 12'hFFF : 12'h000;
      w_out <= issued_out[2] ? 12'h000 : 12'hFFF;
      issued_out <= issued_out + 16'h0001;
    end
  end
endmodule : adc_model
`default_nettype wire

// [shunt_current_spectral_features_tb.sv]
// Self-checking bench: tone frames through the converter model, result timing,
// peak position, serial messages and reset values.
// Assumes the converter model in adc_model.sv and the feature package.
`timescale 1ns/1ps
`default_nettype none
module shunt_current_spectral_features_tb;
  import feature_pkg::*;
  localparam int TICK = 20;
  localparam int LAT = 131094;
  localparam int LIMIT = 320000;
  typedef struct {logic [15:0] count; logic [3:0] delay; logic [7:0] half; logic [7:0] peak;} row_t;
  // DC-heavy U tone at bin 2, then bin 32; V and W carry a louder bin 64 tone
  row_t rows [2] = '{'{16'h0200, 4'h0, 8'h80, 8'h02}, '{16'h01C0, 4'h6, 8'h08, 8'h20}};
  logic [7:0]  wave0 [7] = '{8'h55, 8'h00, 8'h01, 8'h00, 8'h00, 8'hFF, 8'h0F};
  logic        clk_in, srst_in, adc_start_out, adc_valid_in, uart_tx_out, result_valid_out;
  logic [11:0] adc_u_in, adc_v_in, adc_w_in;
  logic [7:0]  anomaly_out, normal_out, peak_bin_out, half;
  logic [15:0] budget, issued;
  logic [3:0]  delay;
  logic [7:0]  rx_q [$];
  int          miscompares, samples_checked, cyc, last_tick, rel_cyc, last_valid, res_cyc, res_cnt;

  shunt_current_spectral_features #(.TICK_CYCLES_P(TICK)) shunt_current_spectral_features_i (
    .clk_in(clk_in), .srst_in(srst_in), .adc_start_out(adc_start_out), .adc_valid_in(adc_valid_in),
    .adc_u_in(adc_u_in), .adc_v_in(adc_v_in), .adc_w_in(adc_w_in), .uart_tx_out(uart_tx_out),
    .anomaly_out(anomaly_out), .normal_out(normal_out), .peak_bin_out(peak_bin_out),
    .result_valid_out(result_valid_out));
  adc_model adc_model_i (
    .clk_in(clk_in), .srst_in(srst_in), .budget_in(budget), .delay_in(delay), .half_in(half),
    .adc_start_in(adc_start_out), .adc_valid_out(adc_valid_in), .u_out(adc_u_in), .v_out(adc_v_in),
    .w_out(adc_w_in), .issued_out(issued));

  initial begin
    clk_in = 1'b0;
    forever #25 clk_in = ~clk_in;
  end

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %s expected %0h seen %0h", name, exp, got);
    end
  endtask : check

  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : report_and_stop

  task automatic check_reset;
    check("reset_outputs", {1'b0, 1'b1, 8'h00, 8'hFF, 8'h00, 1'b0},
          {adc_start_out, uart_tx_out, anomaly_out, normal_out, peak_bin_out, result_valid_out});
  endtask : check_reset

  // Cycle count, tick spacing, valid and result times
  always @(posedge clk_in) begin
    cyc++;
    if (cyc >= LIMIT) begin
      miscompares++;
      report_and_stop();
    end
    if (srst_in) begin
      last_tick = -1;
      rel_cyc = cyc;
    end else if (adc_start_out === 1'b1) begin
      if (last_tick < 0)
        check("first_tick", 1, (cyc - rel_cyc) inside {[TICK - 1:TICK + 1]});
      else
        check("tick_gap", TICK, cyc - last_tick);
      last_tick = cyc;
    end
    if (adc_valid_in === 1'b1)
      last_valid = cyc;
    if (result_valid_out === 1'b1) begin
      res_cyc = cyc;
      res_cnt++;
    end
  end

  // Serial receiver sampling mid-bit, with start bit length check
  initial begin
    logic [7:0] b;
    logic       s0, s1;
    forever begin
      @(posedge clk_in);
      if (srst_in === 1'b0 && uart_tx_out === 1'b0) begin
        repeat (BAUD_CYCLES - 1) @(posedge clk_in);
        s0 = uart_tx_out;
        @(posedge clk_in);
        s1 = uart_tx_out;
        repeat (BAUD_CYCLES / 2) @(posedge clk_in);
        for (int i = 0; i < 8; i++) begin
          b[i] = uart_tx_out;
          repeat (BAUD_CYCLES) @(posedge clk_in);
        end
        check("stop_bit", 1, uart_tx_out);
        if (b[0] === 1'b1)
          check("start_len", 2'b01, {s0, s1});
        rx_q.push_back(b);
      end
    end
  end

  initial begin
    int n;
    int k;
    int h;
    miscompares = 0;
    samples_checked = 0;
    cyc = 0;
    last_tick = -1;
    rel_cyc = 0;
    last_valid = 0;
    res_cyc = 0;
    res_cnt = 0;
    srst_in = 1'b1;
    budget = 16'h0000;
    delay = 4'h0;
    half = 8'h80;
    repeat (5) @(posedge clk_in);
    #1;
    check_reset();
    @(posedge clk_in);
    srst_in <= 1'b0;
    for (int r = 0; r < 2; r++) begin
      @(posedge clk_in);
      delay <= rows[r].delay;
      half <= rows[r].half;
      budget <= budget + rows[r].count;
      n = res_cnt;
      k = 0;
      while (res_cnt == n && k < LAT + 20000) begin
        @(posedge clk_in);
        #1;
        k++;
      end
      check("result_count", n + 1, res_cnt);
      check("result_latency", 1, (res_cyc - last_valid) inside {[LAT - 3:LAT + 3]});
      check("peak_bin", rows[r].peak, peak_bin_out);
      check("normal_sum", 8'hFF - anomaly_out, normal_out);
      repeat (5000) @(posedge clk_in);
      if (r == 0)
        for (int j = 0; j < 7; j++)
          check("wave_byte", wave0[j], (j < rx_q.size()) ? rx_q[j] : 8'hXX);
      h = -1;
      for (int j = rx_q.size() - 1; j >= 0; j--)
        if (rx_q[j] === 8'hAA) h = j;
      check("result_msg_found", 1, h >= 0 && h + 3 < rx_q.size());
      if (h >= 0 && h + 3 < rx_q.size()) begin
        check("msg_anomaly", anomaly_out, rx_q[h + 1]);
        check("msg_normal", normal_out, rx_q[h + 2]);
        check("msg_peak", rows[r].peak, rx_q[h + 3]);
      end
      rx_q.delete();
    end
    @(posedge clk_in);
    srst_in <= 1'b1;
    repeat (6) @(posedge clk_in);
    #1;
    check_reset();
    @(posedge clk_in);
    srst_in <= 1'b0;
    repeat (3 * TICK) @(posedge clk_in);
    report_and_stop();
  end
endmodule : shunt_current_spectral_features_tb
`default_nettype wire
